// *** tb/hlcc_chk_assertions.sv ***
// port-level assertions for the link command and conceal bank
`timescale 1ns/100ps
`include "hlcc_defs.vh"
module hlcc_chk #(
    parameter LINK_ID = `HLCC_LINK_ID_RST
) (
    input wire                   sys_clk,
    input wire                   arst_n,
    input wire                   avs_read,
    input wire                   avs_write,
    input wire                   avs_waitrequest,
    input wire                   req_issue,
    input wire [2:0]             req_src_id_q,
    input wire                   cpl_valid,
    input wire [2:0]             cpl_dest_id,
    input wire                   cpl_for_us_q,
    input wire                   link_msg_done,
    input wire                   link_other_req,
    input wire                   link_slice_expired,
    input wire                   link_yield_q,
    input wire [6:0]             max_packet_bytes,
    input wire                   cfg_cycle,
    input wire [31:0]            cfg_ad,
    input wire [`HLCC_SLOTS-1:0] idsel_out_q,
    input wire                   lan_cfg_hit,
    input wire                   lan_cfg_hit_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // ********************************
    // helper terms
    // ********************************
    wire       cpl_hit = cpl_valid && (cpl_dest_id == LINK_ID);
    wire       yld_c = link_msg_done && link_other_req && link_slice_expired;
    wire [5:0] ad_sel = cfg_ad[21:16];
    // ********************************
    // checks
    // ********************************
    bus_wait_a: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not after one wait");
    id_tag_a: assert property (
        req_issue |=> req_src_id_q == LINK_ID) else $error("bad source id");
    cpl_route_a: assert property (
        cpl_hit |=> cpl_for_us_q) else $error("own completion missed");
    cpl_drop_a: assert property (
        !cpl_hit |=> !cpl_for_us_q) else $error("foreign completion taken");
    yield_on_a: assert property (
        yld_c |=> link_yield_q) else $error("no yield when expired");
    yield_off_a: assert property (
        !yld_c |=> !link_yield_q) else $error("yield without cause");
    slot_pass_a: assert property (
        !cfg_cycle |=> idsel_out_q == $past(ad_sel))
        else $error("idsel not following ad");
    slot_mask_a: assert property (
        cfg_cycle |=> (idsel_out_q & ~$past(ad_sel)) == 6'h00)
        else $error("idsel raised without ad");
    lan_mask_a: assert property (
        lan_cfg_hit_q |-> $past(lan_cfg_hit)) else $error("lan hit uncaused");
    max_data_a: assert property (
        max_packet_bytes == 7'h40) else $error("burst size not 64");
endmodule // hlcc_chk

// *** tb/hlcc_far_model.sv ***
// far-side model: link partner rate strap and pci config targets
`timescale 1ns/100ps
module hlcc_far_model (
    input  wire       sys_clk,
    input  wire [5:0] idsel_out_q,
    output wire [2:0] link_rate_strap,
    output reg  [5:0] devsel_q
);
    // attached link partner only offers the 1:4 rate
    assign link_rate_strap = 3'h2;
    // a target claims the cycle only when it sees its own idsel
    always @(posedge sys_clk) begin
        devsel_q <= idsel_out_q;
    end
endmodule // hlcc_far_model

// *** tb/hlcc_top_tb.sv ***
// self-checking bench for the link command and conceal bank
`timescale 1ns/100ps
`include "hlcc_defs.vh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
    err_total++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module hlcc_top_tb;
    localparam logic [2:0] LINK_ID = 3'h1;
    logic        sys_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  link_rate_strap;
    logic        req_issue = 1'b0;
    logic [2:0]  req_src_id_q;
    logic        cpl_valid = 1'b0;
    logic [2:0]  cpl_dest_id = 3'h0;
    logic        cpl_for_us_q;
    logic        link_own_start = 1'b0;
    logic        link_msg_done = 1'b0;
    logic        link_other_req = 1'b0;
    logic        link_slice_expired;
    logic        link_yield_q;
    logic [6:0]  max_packet_bytes;
    logic        cfg_cycle = 1'b0;
    logic [31:0] cfg_ad = 32'h0;
    logic [5:0]  idsel_out_q;
    logic [5:0]  devsel_q;
    logic        lan_cfg_hit = 1'b0;
    logic        lan_cfg_hit_q;
    logic [5:0]  got_dev;
    logic        got_lan;
    int          err_total = 0;
    int          compares = 0;
    int          cyc = 0;
    hlcc_top #(.LINK_ID(LINK_ID)) u_dut (.*);
    hlcc_far_model u_far (.*);
    // ********************************
    // clock, timeout and verdict
    // ********************************
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            test_done;
        end
    end
    task test_done;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ********************************
    // drivers
    // ********************************
    task automatic bus(input logic rd, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= d;
        avs_byteenable <= be;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // one config cycle hitting slots 0..5 and the lan function
    task cfg;
        @(posedge sys_clk);
        cfg_cycle <= 1'b1;
        cfg_ad <= 32'h013F0000;
        lan_cfg_hit <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        got_dev = devsel_q;
        got_lan = lan_cfg_hit_q;
        @(posedge sys_clk);
        cfg_cycle <= 1'b0;
        cfg_ad <= ~cfg_ad;
        lan_cfg_hit <= 1'b0;
    endtask
    // ********************************
    // scenarios
    // ********************************
    task t_reset_vals;
        logic [31:0] q;
        bus(1, `HLCC_OFF_LINK_CMD, 0, 0, q);
        `CHK("link_cmd", 32'h00202802, q);
        bus(1, `HLCC_OFF_CONCEAL, 0, 0, q);
        `CHK("conceal", 32'h0, q);
    endtask
    task t_regs;
        logic [31:0] q;
        bus(0, `HLCC_OFF_LINK_CMD, 32'hFFFFFFFF, 4'hF, q);
        bus(1, `HLCC_OFF_LINK_CMD, 0, 0, q);
        `CHK("link_cmd", 32'h002F2802, q);
        bus(0, `HLCC_OFF_CONCEAL, 32'hFFFFFFFF, 4'hF, q);
        bus(1, `HLCC_OFF_CONCEAL, 0, 0, q);
        `CHK("conceal", 32'h0000013F, q);
        bus(0, `HLCC_OFF_CONCEAL, 32'h0, 4'h1, q);
        bus(1, `HLCC_OFF_CONCEAL, 0, 0, q);
        `CHK("conceal_lane", 32'h00000100, q);
        bus(0, 8'h48, 32'hFFFFFFFF, 4'hF, q);
        bus(1, 8'h48, 0, 0, q);
        `CHK("unmapped", 32'h0, q);
    endtask
    task t_conceal;
        logic [31:0] q;
        for (int n = 0; n < 6; n++) begin
            bus(0, `HLCC_OFF_CONCEAL, 32'h1 << n, 4'hF, q);
            cfg;
            `CHK("devsel", 6'h3F ^ (6'h01 << n), got_dev);
        end
        bus(0, `HLCC_OFF_CONCEAL, 32'h00000100, 4'hF, q);
        cfg;
        `CHK("devsel_lan", 6'h3F, got_dev);
        `CHK("lan_hit", 1'b0, got_lan);
        bus(0, `HLCC_OFF_CONCEAL, 32'h0, 4'hF, q);
        cfg;
        `CHK("devsel_clr", 6'h3F, got_dev);
        `CHK("lan_clr", 1'b1, got_lan);
    endtask
    task t_pkt;
        `CHK("max_bytes", 7'h40, max_packet_bytes);
        @(posedge sys_clk);
        req_issue <= 1'b1;
        cpl_valid <= 1'b1;
        cpl_dest_id <= 3'h1;
        @(posedge sys_clk);
        req_issue <= 1'b0;
        cpl_dest_id <= 3'h2;
        #1;
        `CHK("src_id", 3'h1, req_src_id_q);
        `CHK("cpl_own", 1'b1, cpl_for_us_q);
        @(posedge sys_clk);
        cpl_valid <= 1'b0;
        #1;
        `CHK("cpl_other", 1'b0, cpl_for_us_q);
    endtask
    task t_slice;
        logic [31:0] q;
        bus(0, `HLCC_OFF_LINK_CMD, 32'h00010000, 4'hF, q);
        @(posedge sys_clk);
        link_own_start <= 1'b1;
        link_other_req <= 1'b1;
        @(posedge sys_clk);
        link_own_start <= 1'b0;
        link_msg_done <= 1'b1;
        #1;
        `CHK("slice_c1", 1'b0, link_slice_expired);
        @(posedge sys_clk);
        link_msg_done <= 1'b0;
        #1;
        `CHK("no_yield", 1'b0, link_yield_q);
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK("slice_c4", 1'b0, link_slice_expired);
        @(posedge sys_clk);
        #1;
        `CHK("slice_c5", 1'b1, link_slice_expired);
        bus(0, `HLCC_OFF_LINK_CMD, 32'h0, 4'hF, q);
        @(posedge sys_clk);
        link_own_start <= 1'b1;
        @(posedge sys_clk);
        link_own_start <= 1'b0;
        link_msg_done <= 1'b1;
        #1;
        `CHK("slice0_exp", 1'b1, link_slice_expired);
        @(posedge sys_clk);
        link_msg_done <= 1'b0;
        link_other_req <= 1'b0;
        #1;
        `CHK("yield", 1'b1, link_yield_q);
    endtask
    // ********************************
    // main sequence
    // ********************************
    initial begin
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        t_reset_vals;
        t_regs;
        t_conceal;
        t_pkt;
        t_slice;
        test_done;
    end
endmodule // hlcc_top_tb
bind hlcc_top hlcc_chk #(.LINK_ID(LINK_ID)) u_chk (.*);

// *** verilog/hlcc_defs.vh ***
// constants for the link command and device conceal register bank
`ifndef HLCC_DEFS_VH
`define HLCC_DEFS_VH

// ***********************************************************
// register byte offsets
// ***********************************************************
`define HLCC_ADDR_W          8
`define HLCC_OFF_LINK_CMD    8'h40
`define HLCC_OFF_CONCEAL     8'h44

// ***********************************************************
// link command register fields
// ***********************************************************
`define HLCC_ID_HI           23
`define HLCC_ID_LO           21
`define HLCC_SLICE_HI        19
`define HLCC_SLICE_LO        16
`define HLCC_WIDTH_HI        15
`define HLCC_WIDTH_LO        14
`define HLCC_RVALID_BIT      13
`define HLCC_RATE_HI         12
`define HLCC_RATE_LO         10
`define HLCC_MAX_PACKET_DATA_HI         3
`define HLCC_MAX_PACKET_DATA_LO         1
`define HLCC_LINK_CMD_RST    32'h00202802
`define HLCC_LINK_ID_RST     3'h1
`define HLCC_SLICE_RST       4'h0
`define HLCC_WIDTH_8BIT      2'h0
`define HLCC_RATE_VALID      1'b1
`define HLCC_RATE_4X         3'h2
`define HLCC_MAX_PACKET_DATA_64B        3'h1
`define HLCC_SLICE_UNIT      32'h00000004
`define HLCC_STRAP_SETTLE    2'h3
`define HLCC_MAX_BYTES       7'h40

// ***********************************************************
// device conceal register fields
// ***********************************************************
`define HLCC_SLOTS           6
`define HLCC_LAN_BIT         8
`define HLCC_IDSEL_BASE      16
`define HLCC_LAN_IDSEL       24
`define HLCC_CONCEAL_RST     6'h00
`define HLCC_LAN_RST         1'b0

`endif

// *** verilog/hlcc_slice_timer.v ***
// arbiter time-slice counter for the upstream link
`timescale 1ns/100ps
`include "hlcc_defs.vh"
module hlcc_slice_timer #(
    parameter CNT_W = 6
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [3:0]       link_arbiter_slice,
    input  wire             own_start,
    input  wire             msg_done,
    input  wire             other_req,
    output wire             slice_expired,
    output reg              yield_q
);

    reg  [CNT_W-1:0] cnt_q;
    reg  [CNT_W-1:0] cnt_d;
    wire [31:0]      load_val;

    // slice scaled to base clocks, wide enough for any slice
    assign load_val = {28'h0000000, link_arbiter_slice} * `HLCC_SLICE_UNIT;

    // ***********************************************************
    // slice countdown
    // ***********************************************************
    // load slice times the unit on taking the link, then count down
    always @* begin
        cnt_d = cnt_q;
        if (own_start) begin
            cnt_d = load_val[CNT_W-1:0];
        end else if (cnt_q != {CNT_W{1'b0}}) begin
            cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= {CNT_W{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // zero slice or spent count means already expired
    assign slice_expired = (cnt_q == {CNT_W{1'b0}});

    // ***********************************************************
    // hand the link over after a message
    // ***********************************************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            yield_q <= 1'b0;
        end else begin
            yield_q <= msg_done & other_req & slice_expired;
        end
    end

endmodule // hlcc_slice_timer

// *** verilog/hlcc_top.v ***
// link command and device conceal registers with avalon-mm access
//
// Summary of operation
// - read-only link id, used to tag requests and route completions
// - writable 4-bit arbiter slice, counted in units of 4 clocks
// - zero slice is expired; other master served after a message only once the slice is spent
// - link width field always reads 00, an 8-bit link
// - rate valid bit always reads one
// - rate field loads 010 (1:4) at reset, then takes the strap once it has settled after reset release
// - max data field reads 001; packets always burst 64 bytes
// - concealed slot keeps its idsel low during configuration cycles
// - slot n idsel is ad line 16 plus n, controlled by bit n
// - bit 8 conceals the lan function by masking its config decode
// - lan conceal leaves the bus configuration cycle untouched
// - clear conceal bit passes configuration cycles unmodified
// - conceal register reads zero after reset
`timescale 1ns/100ps
`include "hlcc_defs.vh"
module hlcc_top #(
    parameter LINK_ID = `HLCC_LINK_ID_RST
) (
    input  wire                    sys_clk,
    input  wire                    arst_n,
    // avalon-mm slave
    input  wire [`HLCC_ADDR_W-1:0] avs_address,
    input  wire                    avs_read,
    input  wire                    avs_write,
    input  wire [31:0]             avs_writedata,
    input  wire [3:0]              avs_byteenable,
    output reg  [31:0]             avs_readdata,
    output wire                    avs_waitrequest,
    // rate strap from the attached link partner
    input  wire [2:0]              link_rate_strap,
    // upstream link packets
    input  wire                    req_issue,
    output reg  [2:0]              req_src_id_q,
    input  wire                    cpl_valid,
    input  wire [2:0]              cpl_dest_id,
    output reg                     cpl_for_us_q,
    // upstream link arbitration
    input  wire                    link_own_start,
    input  wire                    link_msg_done,
    input  wire                    link_other_req,
    output wire                    link_slice_expired,
    output wire                    link_yield_q,
    output wire [6:0]              max_packet_bytes,
    // pci configuration cycles
    input  wire                    cfg_cycle,
    input  wire [31:0]             cfg_ad,
    output reg  [`HLCC_SLOTS-1:0]  idsel_out_q,
    input  wire                    lan_cfg_hit,
    output reg                     lan_cfg_hit_q
);

    // ***********************************************************
    // reset release
    // ***********************************************************
    reg              rst_meta_q;
    reg              rst_n_q;

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ***********************************************************
    // fixed link identity
    // ***********************************************************
    wire [2:0]       link_id_w;

    // identity cut to the 3-bit field once, shared by all users
    assign link_id_w = LINK_ID[2:0];

    // ***********************************************************
    // rate strap capture
    // ***********************************************************
    reg  [2:0]       strap_meta_q;
    reg  [2:0]       strap_sync_q;
    reg  [1:0]       strap_wait_q;
    wire             strap_ready;
    reg              strap_done_q;
    reg  [2:0]       link_rate_code_q;

    // two-stage synchroniser on the strap pins
    always @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            strap_meta_q <= 3'h0;
            strap_sync_q <= 3'h0;
        end else begin
            strap_meta_q <= link_rate_strap;
            strap_sync_q <= strap_meta_q;
        end
    end

    // settle count so the strap is read only once it has passed both flops
    always @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            strap_wait_q <= 2'h0;
        end else if (!strap_ready) begin
            strap_wait_q <= strap_wait_q + 2'h1;
        end
    end

    // strap trusted after the settle count
    assign strap_ready = (strap_wait_q == `HLCC_STRAP_SETTLE);

    // take the strap once, after it has passed the synchroniser
    always @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            strap_done_q     <= 1'b0;
            link_rate_code_q <= `HLCC_RATE_4X;
        end else if (!strap_done_q && strap_ready) begin
            strap_done_q     <= 1'b1;
            link_rate_code_q <= strap_sync_q;
        end
    end

    // ***********************************************************
    // bus slave handshake
    // ***********************************************************
    reg              ack_q;
    wire             req_any;
    wire             wr_en;
    wire             hit_cmd;
    wire             hit_conceal;
    wire             rd_take;
    wire             wr_slice;
    wire             wr_slots;
    wire             wr_lan;

    assign req_any         = avs_read | avs_write;
    assign avs_waitrequest = req_any & ~ack_q;
    assign wr_en           = avs_write & ack_q;
    assign rd_take         = avs_read & ~ack_q;
    assign hit_cmd         = (avs_address == `HLCC_OFF_LINK_CMD);
    assign hit_conceal     = (avs_address == `HLCC_OFF_CONCEAL);

    // lane-qualified strobes; other lanes hold only reserved or read-only bits
    assign wr_slice = wr_en & hit_cmd & avs_byteenable[2];
    assign wr_slots = wr_en & hit_conceal & avs_byteenable[0];
    assign wr_lan   = wr_en & hit_conceal & avs_byteenable[1];

    // one wait cycle for every access
    always @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req_any & ~ack_q;
        end
    end

    // ***********************************************************
    // writable fields
    // ***********************************************************
    reg  [3:0]              link_arbiter_slice_q;
    reg  [`HLCC_SLOTS-1:0]  conceal_slot_q;
    reg                     conceal_lan_function_q;

    // only the slice bits of the command word take writes
    always @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            link_arbiter_slice_q <= `HLCC_SLICE_RST;
        end else if (wr_slice) begin
            link_arbiter_slice_q <=
                avs_writedata[`HLCC_SLICE_HI:`HLCC_SLICE_LO];
        end
    end

    // slot conceal bits live in byte 0
    always @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            conceal_slot_q <= `HLCC_CONCEAL_RST;
        end else if (wr_slots) begin
            conceal_slot_q <= avs_writedata[`HLCC_SLOTS-1:0];
        end
    end

    // lan conceal bit lives in byte 1
    always @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            conceal_lan_function_q <= `HLCC_LAN_RST;
        end else if (wr_lan) begin
            conceal_lan_function_q <=
                avs_writedata[`HLCC_LAN_BIT];
        end
    end

    // ***********************************************************
    // read data
    // ***********************************************************
    reg  [31:0]      cmd_word;
    reg  [31:0]      conceal_word;

    // command read view, reserved bits held at zero
    always @* begin
        cmd_word = 32'h00000000;
        cmd_word[`HLCC_ID_HI:`HLCC_ID_LO] = link_id_w;
        cmd_word[`HLCC_SLICE_HI:`HLCC_SLICE_LO] = link_arbiter_slice_q;
        cmd_word[`HLCC_WIDTH_HI:`HLCC_WIDTH_LO] = `HLCC_WIDTH_8BIT;
        cmd_word[`HLCC_RVALID_BIT] = `HLCC_RATE_VALID;
        cmd_word[`HLCC_RATE_HI:`HLCC_RATE_LO] = link_rate_code_q;
        cmd_word[`HLCC_MAX_PACKET_DATA_HI:`HLCC_MAX_PACKET_DATA_LO] = `HLCC_MAX_PACKET_DATA_64B;
    end

    // conceal read view, reserved bits held at zero
    always @* begin
        conceal_word = 32'h00000000;
        conceal_word[`HLCC_SLOTS-1:0] = conceal_slot_q;
        conceal_word[`HLCC_LAN_BIT] = conceal_lan_function_q;
    end

    // read data registered in the wait cycle, zero when unmapped
    always @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            avs_readdata <= 32'h00000000;
        end else if (rd_take) begin
            if (hit_cmd) begin
                avs_readdata <= cmd_word;
            end else if (hit_conceal) begin
                avs_readdata <= conceal_word;
            end else begin
                avs_readdata <= 32'h00000000;
            end
        end
    end

    // ***********************************************************
    // upstream link packet identity
    // ***********************************************************
    // tag every issued request with our id
    always @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            req_src_id_q <= 3'h0;
        end else if (req_issue) begin
            req_src_id_q <= link_id_w;
        end
    end

    // flag completions that route back to us, one cycle
    always @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cpl_for_us_q <= 1'b0;
        end else begin
            cpl_for_us_q <= cpl_valid & (cpl_dest_id == link_id_w);
        end
    end

    // ***********************************************************
    // packet size
    // ***********************************************************
    // every packet bursts the full 64 bytes
    assign max_packet_bytes = `HLCC_MAX_BYTES;

    // ***********************************************************
    // arbiter time slice
    // ***********************************************************
    hlcc_slice_timer #(
        .CNT_W              (6)
    ) u_slice (
        .clk                (sys_clk),
        .rst_n              (rst_n_q),
        .link_arbiter_slice (link_arbiter_slice_q),
        .own_start          (link_own_start),
        .msg_done           (link_msg_done),
        .other_req          (link_other_req),
        .slice_expired      (link_slice_expired),
        .yield_q            (link_yield_q)
    );

    // ***********************************************************
    // configuration idsel masking
    // ***********************************************************
    genvar g;
    generate
        for (g = 0; g < `HLCC_SLOTS; g = g + 1) begin : g_slot
            // slot g follows ad line 16+g unless concealed in config
            always @(posedge sys_clk or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    idsel_out_q[g] <= 1'b0;
                end else if (cfg_cycle && conceal_slot_q[g]) begin
                    idsel_out_q[g] <= 1'b0;
                end else begin
                    idsel_out_q[g] <=
                        cfg_ad[`HLCC_IDSEL_BASE + g];
                end
            end
        end
    endgenerate

    // lan decode masked internally, bus cycle left as it is
    always @(posedge sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lan_cfg_hit_q <= 1'b0;
        end else begin
            lan_cfg_hit_q <=
                lan_cfg_hit & ~conceal_lan_function_q;
        end
    end

endmodule // hlcc_top
